// ===== ivaa_pkg.sv
package ivaa_pkg;

  // ==========================================================================
  // register addresses and reset values
  localparam logic [19:0] RISE_SEL_ADDR  = 20'hfff38;
  localparam logic [19:0] FALL_SEL_ADDR  = 20'hfff39;
  localparam logic [7:0]  EDGE_SEL_RESET = 8'h00;
  localparam logic [7:0]  PSW_RESET      = 8'h06;
  localparam logic        MASK_RESET_BIT = 1'b1;

  // ==========================================================================
  // status word fields
  localparam int PSW_IE_BIT   = 7;
  localparam int PSW_SERVICED_LEVEL_HI_BIT = 2;
  localparam int PSW_SERVICED_LEVEL_LO_BIT = 1;

  // ==========================================================================
  // vectors and timing
  localparam logic [19:0] TRAP_VEC_ADDR = 20'h0007e;
  localparam logic [19:0] VEC_BASE_ADDR = 20'h00004;
  localparam int          ACK_MIN_CYC   = 9;
  localparam int          ACK_MAX_CYC   = 14;
  localparam logic [3:0]  SEQ_LAST_CNT  = 4'(ACK_MIN_CYC - 1);

  // ==========================================================================
  // acceptance sequencer states, gray along the path
  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_PUSH_PSW = 2'b01,
    SEQ_PUSH_PC  = 2'b11,
    SEQ_VECTOR   = 2'b10
  } ivaa_seq_t;

  // ==========================================================================
  // decoders
  function automatic logic edge_hit(input logic rise_sel,
                                    input logic fall_sel,
                                    input logic rose,
                                    input logic fell);
    return (rise_sel & rose) | (fall_sel & fell);
  endfunction

  function automatic logic level_ok(input logic [1:0] lvl,
                                    input logic [1:0] isp);
    return lvl <= isp;
  endfunction

endpackage

// ===== ivaa_arb_if.sv
`timescale 1ns/100ps
interface ivaa_arb_if #(parameter int SRC = 16);
  logic [SRC-1:0]         req;
  logic [SRC-1:0]         mask;
  logic [SRC-1:0]         lvl_bit0;
  logic [SRC-1:0]         lvl_bit1;
  logic                   found;
  logic [$clog2(SRC)-1:0] idx;
  logic [1:0]             level;

  modport ctrl (output req, mask, lvl_bit0, lvl_bit1,
                input  found, idx, level);
  modport arb  (input  req, mask, lvl_bit0, lvl_bit1,
                output found, idx, level);
endinterface

// ===== ivaa_edge.sv
`timescale 1ns/100ps
module ivaa_edge #(
  parameter int PINS = 8
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic [PINS-1:0] pin_i,
  input  wire logic [PINS-1:0] rise_sel_i,
  input  wire logic [PINS-1:0] fall_sel_i,
  output logic      [PINS-1:0] hit_o
);

  // ==========================================================================
  // per pin synchroniser and edge decode
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    logic s1;
    logic s2;
    logic s3;
    logic stable;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
      end else begin
        s1 <= pin_i[p];
        s2 <= s1;
        s3 <= s2;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        stable <= 1'b0;
      end else if (s2 == s3) begin
        stable <= s3;
      end
    end

    always_comb begin
      hit_o[p] = (s2 == s3) && ivaa_pkg::edge_hit(rise_sel_i[p],
                   fall_sel_i[p], s3 & ~stable, ~s3 & stable); // see (RULE1)
    end
  end

endmodule

// ===== ivaa_arb.sv
`timescale 1ns/100ps
module ivaa_arb #(
  parameter int SRC = 16
) (
  ivaa_arb_if.arb a
);

  // ==========================================================================
  // best level first, lowest index wins a tie
  always_comb begin
    logic [1:0] lvl;
    lvl     = 2'b00;
    a.found = 1'b0;
    a.idx   = '0;
    a.level = 2'b11;
    for (int s = 0; s < SRC; s++) begin
      lvl = {a.lvl_bit1[s], a.lvl_bit0[s]}; // see (RULE19)
      if (a.req[s] && !a.mask[s]) begin // see (RULE8)
        if (!a.found || lvl < a.level) begin // see (RULE11)
          a.found = 1'b1;
          a.idx   = ($clog2(SRC))'(s);
          a.level = lvl;
        end
      end
    end
  end

endmodule

// ===== ivaa_ctrl.sv
// Operation
// (RULE1) edge select pair: none, falling, rising, or both edges per pin
// (RULE2) reset clears rising and falling edge select registers to zero
// (RULE3) six-pin variant: bits 6 and 7 of edge selects read zero
// (RULE4) software clears edge selects before giving a pin to port use
// (RULE5) reset loads status word with 06h, acceptance off, all levels open
// (RULE6) serviced level 00 takes 0, 01 up to 1, 10 up to 2, 11 all
// (RULE7) accept-enable bit zero blocks every maskable request
// (RULE8) source eligible only with request set and mask clear
// (RULE9) vectored only with enable set and no higher level in service
// (RULE10) request to handler start takes 9 to 14 clocks
// (RULE11) coinciding requests: best level first, ties by fixed source order
// (RULE12) unaccepted request waits and is taken once conditions hold
// (RULE13) accept: push status, push pc, clear enable, copy level, vector
// (RULE14) status restored by returns and pop, pushed by push-status
// (RULE15) software trap always taken: push, clear enable, vector at 7eh
// (RULE16) software trap handlers leave with the trap return only
// (RULE17) nested service needs enable set again; equal or better level only
// (RULE18) after a return one interrupted instruction runs before acceptance
// (RULE19) level bits high then low: 00 best level 0, 11 worst level 3
// (RULE20) mask zero enables its source, one disables; masks reset to ones
// (RULE21) hold-class instruction defers acceptance past the next instruction
// (RULE22) a selected edge on an external pin sets that pin's request flag
// (RULE23) status word: enable at bit 7, level high bit 2, low bit 1
`timescale 1ns/100ps
module ivaa_ctrl #(
  parameter int EXT_PINS = 8,
  parameter int SRC      = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // special function register access
  input  wire logic [19:0]            sfr_addr_i,
  input  wire logic                   sfr_wr_i,
  input  wire logic                   sfr_rd_i,
  input  wire logic [7:0]             sfr_wdata_i,
  output logic      [7:0]             sfr_rdata_o,
  // status word access
  input  wire logic                   psw_wr_i,
  input  wire logic [7:0]             psw_wdata_i,
  input  wire logic [7:0]             psw_stack_i,
  output logic      [7:0]             psw_o,
  // instruction sequencer
  input  wire logic                   instr_done_i,
  input  wire logic                   instr_hold_i,
  input  wire logic                   enable_irq_instr_i,
  input  wire logic                   irq_block_instr_i,
  input  wire logic                   soft_trap_instr_i,
  input  wire logic                   irq_return_instr_i,
  input  wire logic                   trap_return_instr_i,
  input  wire logic                   pop_psw_i,
  input  wire logic                   push_psw_i,
  output logic                        seq_busy_o,
  output logic                        push_psw_o,
  output logic                        push_pc_o,
  output logic      [7:0]             push_data_o,
  output logic                        handler_start_o,
  output logic      [19:0]            vector_addr_o,
  output logic                        vector_is_trap_o,
  // source flags
  input  wire logic [EXT_PINS-1:0]    ext_irq_pin_i,
  output logic      [EXT_PINS-1:0]    ext_irq_set_o,
  input  wire logic [SRC-1:0]         irq_request_flag_i,
  input  wire logic                   mask_wr_i,
  input  wire logic [SRC-1:0]         mask_wdata_i,
  output logic      [SRC-1:0]         irq_mask_flag_o,
  input  wire logic [SRC-1:0]         level_sel_bit0_i,
  input  wire logic [SRC-1:0]         level_sel_bit1_i,
  output logic      [SRC-1:0]         irq_ack_clear_o
);

  // ==========================================================================
  // parameter checks
  if (EXT_PINS != 6 && EXT_PINS != 8) begin : g_bad_pins
    $error("ext pins must be 6 or 8");
  end
  if (SRC < 2 || SRC > 64) begin : g_bad_src
    $error("source count out of range");
  end

  localparam logic [7:0] PIN_MASK = 8'((1 << EXT_PINS) - 1);

  // ==========================================================================
  // declarations
  logic [7:0]                 rise_edge_sel;
  logic [7:0]                 fall_edge_sel;
  logic [7:0]                 program_status_word;
  logic [7:0]                 psw_saved;
  logic [SRC-1:0]             mask;
  ivaa_pkg::ivaa_seq_t        state;
  ivaa_pkg::ivaa_seq_t        next_state;
  logic [3:0]                 cnt;
  logic                       cur_trap;
  logic [$clog2(SRC)-1:0]     cur_idx;
  logic                       defer_pending;
  logic                       after_return;
  logic                       take_irq;
  logic                       take_trap;
  logic                       boundary_ok;
  logic                       irq_en;
  logic [1:0]                 isp;
  logic                       any_return;

  ivaa_arb_if #(.SRC(SRC)) arb_bus ();

  // ==========================================================================
  // edge select registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_edge_sel <= ivaa_pkg::EDGE_SEL_RESET; // see (RULE2)
      fall_edge_sel <= ivaa_pkg::EDGE_SEL_RESET; // see (RULE2)
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == ivaa_pkg::RISE_SEL_ADDR) begin
        rise_edge_sel <= sfr_wdata_i & PIN_MASK; // see (RULE3)
      end
      if (sfr_addr_i == ivaa_pkg::FALL_SEL_ADDR) begin
        fall_edge_sel <= sfr_wdata_i & PIN_MASK; // see (RULE3)
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        ivaa_pkg::RISE_SEL_ADDR: sfr_rdata_o <= rise_edge_sel;
        ivaa_pkg::FALL_SEL_ADDR: sfr_rdata_o <= fall_edge_sel;
        default:                 sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // external pin edge detection
  ivaa_edge #(.PINS(EXT_PINS)) u_edge (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (ext_irq_pin_i),
    .rise_sel_i (rise_edge_sel[EXT_PINS-1:0]),
    .fall_sel_i (fall_edge_sel[EXT_PINS-1:0]),
    .hit_o      (ext_irq_set_o) // see (RULE22)
  );

  // ==========================================================================
  // mask flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= {SRC{ivaa_pkg::MASK_RESET_BIT}}; // see (RULE20)
    end else if (mask_wr_i) begin
      mask <= mask_wdata_i;
    end
  end

  assign irq_mask_flag_o = mask;

  // ==========================================================================
  // arbitration
  assign arb_bus.req      = irq_request_flag_i;
  assign arb_bus.mask     = mask;
  assign arb_bus.lvl_bit0 = level_sel_bit0_i;
  assign arb_bus.lvl_bit1 = level_sel_bit1_i;

  ivaa_arb #(.SRC(SRC)) u_arb (
    .a (arb_bus.arb)
  );

  // ==========================================================================
  // acceptance decision
  assign irq_en     = program_status_word[ivaa_pkg::PSW_IE_BIT]; // see (RULE23)
  assign isp        = {program_status_word[ivaa_pkg::PSW_SERVICED_LEVEL_HI_BIT],
                       program_status_word[ivaa_pkg::PSW_SERVICED_LEVEL_LO_BIT]}; // see (RULE23)
  assign any_return = irq_return_instr_i | trap_return_instr_i;

  // an instruction boundary where acceptance may happen at all
  assign boundary_ok = instr_done_i && !instr_hold_i && !any_return &&
                       !defer_pending && !after_return &&
                       !soft_trap_instr_i && !psw_wr_i &&
                       !enable_irq_instr_i && !irq_block_instr_i &&
                       !pop_psw_i && !mask_wr_i; // see (RULE21)

  assign take_trap = (state == ivaa_pkg::SEQ_IDLE) &&
                     soft_trap_instr_i; // see (RULE15)

  assign take_irq = (state == ivaa_pkg::SEQ_IDLE) && boundary_ok &&
                    irq_en && arb_bus.found && // see (RULE7)
                    ivaa_pkg::level_ok(arb_bus.level, isp); // see (RULE9)
  // a blocked request is simply re-evaluated at every later boundary
  // see (RULE12) (RULE6) (RULE17)

  // ==========================================================================
  // deferral after hold-class instructions and returns
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      defer_pending <= 1'b0;
    end else if (instr_done_i) begin
      defer_pending <= instr_hold_i | psw_wr_i | enable_irq_instr_i |
                       irq_block_instr_i | pop_psw_i |
                       mask_wr_i; // see (RULE21)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      after_return <= 1'b0;
    end else if (instr_done_i) begin
      after_return <= any_return; // see (RULE18)
    end
  end

  // ==========================================================================
  // status word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      program_status_word <= ivaa_pkg::PSW_RESET; // see (RULE5)
    end else if (take_trap) begin
      program_status_word[ivaa_pkg::PSW_IE_BIT] <= 1'b0; // see (RULE15)
    end else if (take_irq) begin
      program_status_word[ivaa_pkg::PSW_IE_BIT]   <= 1'b0; // see (RULE13)
      program_status_word[ivaa_pkg::PSW_SERVICED_LEVEL_HI_BIT] <= arb_bus.level[1]; // see (RULE13)
      program_status_word[ivaa_pkg::PSW_SERVICED_LEVEL_LO_BIT] <= arb_bus.level[0]; // see (RULE13)
    end else if (any_return || pop_psw_i) begin
      program_status_word <= psw_stack_i; // see (RULE14)
    end else if (enable_irq_instr_i) begin
      program_status_word[ivaa_pkg::PSW_IE_BIT] <= 1'b1; // see (RULE17)
    end else if (irq_block_instr_i) begin
      program_status_word[ivaa_pkg::PSW_IE_BIT] <= 1'b0;
    end else if (psw_wr_i) begin
      program_status_word <= psw_wdata_i;
    end
  end

  assign psw_o = program_status_word;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psw_saved <= ivaa_pkg::PSW_RESET;
    end else if (take_trap || take_irq) begin
      psw_saved <= program_status_word;
    end
  end

  // ==========================================================================
  // acceptance sequencer
  always_comb begin
    next_state = state;
    case (state)
      ivaa_pkg::SEQ_IDLE: begin
        if (take_trap || take_irq) begin
          next_state = ivaa_pkg::SEQ_PUSH_PSW;
        end
      end
      ivaa_pkg::SEQ_PUSH_PSW: next_state = ivaa_pkg::SEQ_PUSH_PC;
      ivaa_pkg::SEQ_PUSH_PC:  next_state = ivaa_pkg::SEQ_VECTOR;
      ivaa_pkg::SEQ_VECTOR: begin
        if (cnt == ivaa_pkg::SEQ_LAST_CNT) begin
          next_state = ivaa_pkg::SEQ_IDLE;
        end
      end
      default: next_state = ivaa_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ivaa_pkg::SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
    end else if (state == ivaa_pkg::SEQ_IDLE) begin
      cnt <= (take_trap || take_irq) ? 4'h1 : 4'h0;
    end else begin
      cnt <= cnt + 4'h1; // see (RULE10)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_trap      <= 1'b0;
      cur_idx       <= '0;
      vector_addr_o <= 20'h00000;
    end else if (take_trap) begin
      cur_trap      <= 1'b1;
      vector_addr_o <= ivaa_pkg::TRAP_VEC_ADDR; // see (RULE15)
    end else if (take_irq) begin
      cur_trap      <= 1'b0;
      cur_idx       <= arb_bus.idx;
      vector_addr_o <= ivaa_pkg::VEC_BASE_ADDR +
                       {19'(arb_bus.idx), 1'b0}; // see (RULE13)
    end
  end

  // clear the accepted source's request flag once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ack_clear_o <= '0;
    end else begin
      irq_ack_clear_o <= '0;
      if (take_irq && !take_trap) begin
        irq_ack_clear_o[arb_bus.idx] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // outputs toward the instruction sequencer
  assign seq_busy_o       = (state != ivaa_pkg::SEQ_IDLE);
  assign push_psw_o       = (state == ivaa_pkg::SEQ_PUSH_PSW) ||
                            push_psw_i; // see (RULE14)
  assign push_pc_o        = (state == ivaa_pkg::SEQ_PUSH_PC); // see (RULE13)
  assign push_data_o      = (state == ivaa_pkg::SEQ_PUSH_PSW) ? psw_saved
                                                               : program_status_word;
  assign handler_start_o  = (state == ivaa_pkg::SEQ_VECTOR) &&
                            (cnt == ivaa_pkg::SEQ_LAST_CNT); // see (RULE10)
  assign vector_is_trap_o = cur_trap;

endmodule

// ===== ivaa_ctrl_props.sv
`timescale 1ns/100ps
module ivaa_ctrl_props #(
  parameter int EXT_PINS = 8,
  parameter int SRC      = 16
) (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic [7:0]          psw_o,
  input wire logic                seq_busy_o,
  input wire logic                push_psw_o,
  input wire logic                push_pc_o,
  input wire logic                handler_start_o,
  input wire logic [19:0]         vector_addr_o,
  input wire logic                vector_is_trap_o,
  input wire logic [SRC-1:0]      irq_request_flag_i,
  input wire logic                mask_wr_i,
  input wire logic [SRC-1:0]      irq_mask_flag_o,
  input wire logic [SRC-1:0]      level_sel_bit0_i,
  input wire logic [SRC-1:0]      level_sel_bit1_i,
  input wire logic [SRC-1:0]      irq_ack_clear_o,
  input wire logic [EXT_PINS-1:0] ext_irq_set_o
);
  logic [1:0] ack_lvl;
  logic       acc;
  // =====
  // level of the source being acknowledged
  assign ack_lvl = {|(level_sel_bit1_i & irq_ack_clear_o),
                    |(level_sel_bit0_i & irq_ack_clear_o)};
  assign acc = seq_busy_o && !vector_is_trap_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_PUSH_ORDER: assert property (
    $rose(seq_busy_o) |-> push_psw_o ##1 push_pc_o)
    else $error("status and pc pushes out of order");
  AST_LATENCY: assert property (
    $rose(seq_busy_o) |-> ##7 handler_start_o ##1 !seq_busy_o)
    else $error("handler start not at fixed latency");
  AST_IE_CLEAR: assert property (
    $rose(seq_busy_o) |-> !psw_o[7])
    else $error("enable bit not cleared on acceptance");
  AST_GATE: assert property (
    $rose(acc) |-> $past(psw_o[7]))
    else $error("accepted while enable bit clear");
  AST_LEVEL_COPY: assert property (
    $rose(acc) |-> psw_o[2:1] == ack_lvl)
    else $error("serviced level not copied");
  AST_LEVEL_OK: assert property (
    $rose(acc) |-> ack_lvl <= $past(psw_o[2:1]))
    else $error("accepted level below serviced level");
  AST_ELIGIBLE: assert property (
    $rose(acc) |-> $onehot(irq_ack_clear_o) && (irq_ack_clear_o &
      $past(irq_request_flag_i) & ~$past(irq_mask_flag_o)) != '0)
    else $error("accepted source not eligible");
  AST_TRAP_VEC: assert property (
    $rose(seq_busy_o) && vector_is_trap_o |->
      vector_addr_o == ivaa_pkg::TRAP_VEC_ADDR)
    else $error("trap vector wrong");
  AST_MASK_HOLD: assert property (
    !$past(mask_wr_i) |-> $stable(irq_mask_flag_o))
    else $error("mask changed without write");
  cover property ($rose(acc));
  cover property ($rose(seq_busy_o) && vector_is_trap_o);
  cover property (ext_irq_set_o[0]);
endmodule
bind ivaa_ctrl ivaa_ctrl_props #(.EXT_PINS(EXT_PINS), .SRC(SRC)) props_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psw_o(psw_o),
  .seq_busy_o(seq_busy_o), .push_psw_o(push_psw_o), .push_pc_o(push_pc_o),
  .handler_start_o(handler_start_o), .vector_addr_o(vector_addr_o),
  .vector_is_trap_o(vector_is_trap_o),
  .irq_request_flag_i(irq_request_flag_i), .mask_wr_i(mask_wr_i),
  .irq_mask_flag_o(irq_mask_flag_o), .level_sel_bit0_i(level_sel_bit0_i),
  .level_sel_bit1_i(level_sel_bit1_i), .irq_ack_clear_o(irq_ack_clear_o),
  .ext_irq_set_o(ext_irq_set_o));

// ===== ivaa_cpu_model.sv
`timescale 1ns/100ps
module ivaa_cpu_model #(
  parameter int SRC  = 16,
  parameter int PINS = 6
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            run_i,
  input  wire logic            flag_wr_i,
  input  wire logic [SRC-1:0]  flag_wdata_i,
  input  wire logic [PINS-1:0] ext_set_i,
  input  wire logic [SRC-1:0]  ack_clear_i,
  input  wire logic            busy_i,
  output logic      [SRC-1:0]  flag_o,
  output logic                 done_o
);
  logic phase;
  // =====
  // instruction boundaries every second clock, none while sequencing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      phase  <= !phase;
      done_o <= run_i && phase && !busy_i;
    end
  end
  // =====
  // request flags: set by edges or flag writes, kept until acknowledged or rewritten
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= '0;
    end else if (flag_wr_i) begin
      flag_o <= flag_wdata_i;
    end else begin
      flag_o <= (flag_o | SRC'(ext_set_i)) & ~ack_clear_i;
    end
  end
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("unexpected %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
  localparam int SRC = 16;
  typedef struct packed {
    logic [3:0] src;
    logic [1:0] lvl;
    logic       msk;
    logic [7:0] program_status_word;
    logic       acc;
  } ivaa_row_t;
  logic clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, psw_wr_i, tb_done, run, flag_wr;
  logic eirq, soft_trap, irq_ret, trap_ret, mask_wr_i, seen, seq_busy_o;
  logic handler_start_o, vector_is_trap_o, cpu_done, pop, di;
  logic [7:0] push_data;
  logic [19:0] sfr_addr_i, vector_addr_o;
  logic [7:0] sfr_wdata_i, sfr_rdata_o, psw_wdata_i, psw_stack_i, psw_o;
  logic [5:0] ext_irq_pin_i, ext_set;
  logic [SRC-1:0] mask_wdata_i, lvl0, lvl1, flags, flag_wdata, ack, masks;
  int fails, samples_checked, cyc, ecnt, bcnt, cycles;
  ivaa_row_t rows[10] = '{
    '{4'd3, 2'd2, 1'b0, 8'h86, 1'b1}, '{4'd3, 2'd2, 1'b1, 8'h86, 1'b0},
    '{4'd3, 2'd0, 1'b0, 8'h06, 1'b0}, '{4'd5, 2'd1, 1'b0, 8'h82, 1'b1},
    '{4'd5, 2'd2, 1'b0, 8'h82, 1'b0}, '{4'd9, 2'd0, 1'b0, 8'h80, 1'b1},
    '{4'd9, 2'd1, 1'b0, 8'h80, 1'b0}, '{4'd12, 2'd3, 1'b0, 8'h84, 1'b0},
    '{4'd12, 2'd2, 1'b0, 8'h84, 1'b1}, '{4'd15, 2'd3, 1'b0, 8'h86, 1'b1}};
  ivaa_ctrl #(.EXT_PINS(6), .SRC(SRC)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .psw_wr_i(psw_wr_i), .psw_wdata_i(psw_wdata_i),
    .psw_stack_i(psw_stack_i), .psw_o(psw_o),
    .instr_done_i(cpu_done | tb_done), .instr_hold_i(1'b0),
    .enable_irq_instr_i(eirq), .irq_block_instr_i(di),
    .soft_trap_instr_i(soft_trap), .irq_return_instr_i(irq_ret),
    .trap_return_instr_i(trap_ret), .pop_psw_i(pop), .push_psw_i(1'b0),
    .seq_busy_o(seq_busy_o), .push_psw_o(), .push_pc_o(),
    .push_data_o(push_data),
    .handler_start_o(handler_start_o), .vector_addr_o(vector_addr_o),
    .vector_is_trap_o(vector_is_trap_o), .ext_irq_pin_i(ext_irq_pin_i),
    .ext_irq_set_o(ext_set), .irq_request_flag_i(flags),
    .mask_wr_i(mask_wr_i), .mask_wdata_i(mask_wdata_i),
    .irq_mask_flag_o(masks), .level_sel_bit0_i(lvl0),
    .level_sel_bit1_i(lvl1), .irq_ack_clear_o(ack));
  ivaa_cpu_model #(.SRC(SRC), .PINS(6)) cpu_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .flag_wr_i(flag_wr),
    .flag_wdata_i(flag_wdata), .ext_set_i(ext_set), .ack_clear_i(ack),
    .busy_i(seq_busy_o), .flag_o(flags), .done_o(cpu_done));
  // =====
  // clock, timeout and event counters
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (ext_set[0] === 1'b1) ecnt++;
    if (cpu_done === 1'b1 && seq_busy_o === 1'b0) bcnt++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sfr(input logic wr, input logic [19:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = wr;
    sfr_rd_i = !wr;
    tick();
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    tick();
  endtask
  task automatic setup(input logic [7:0] p, input logic [SRC-1:0] m);
    run = 1'b0;
    flag_wdata = '0;
    flag_wr = 1'b1;
    psw_wdata_i = p;
    psw_wr_i = 1'b1;
    mask_wdata_i = m;
    mask_wr_i = 1'b1;
    tick();
    {flag_wr, psw_wr_i, mask_wr_i} = 3'b000;
    tick(3);
  endtask
  task automatic raise(input logic [SRC-1:0] f);
    flag_wdata = f;
    flag_wr = 1'b1;
    run = 1'b1;
    tick();
    flag_wr = 1'b0;
    seen = 1'b0;
    cyc = 0;
    while (!seen && cyc < 24) begin
      tick();
      cyc++;
      seen = (handler_start_o === 1'b1);
    end
  endtask
  task automatic instr(input logic [3:0] op, input logic [7:0] stk);
    psw_stack_i = stk;
    {eirq, soft_trap, irq_ret, trap_ret} = op;
    tb_done = 1'b1;
    tick();
    {eirq, soft_trap, irq_ret, trap_ret, tb_done} = 5'b00000;
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // =====
  // main sequence
  initial begin
    {rst_n_i, sfr_wr_i, sfr_rd_i, psw_wr_i, tb_done, run, flag_wr} = '0;
    {eirq, soft_trap, irq_ret, trap_ret, mask_wr_i, pop, di} = '0;
    {sfr_addr_i, sfr_wdata_i, psw_wdata_i, psw_stack_i} = '0;
    {ext_irq_pin_i, mask_wdata_i, flag_wdata} = '0;
    lvl0 = '1;
    lvl1 = '1;
    tick(8);
    rst_n_i = 1'b1;
    tick(4);
    foreach (rows[i]) begin
      lvl0 = '1;
      lvl1 = '1;
      lvl0[rows[i].src] = rows[i].lvl[0];
      lvl1[rows[i].src] = rows[i].lvl[1];
      setup(rows[i].program_status_word, ~(SRC'(!rows[i].msk) << rows[i].src));
      raise(SRC'(1) << rows[i].src);
      `CHK(seen, rows[i].acc)
      `CHK(flags[rows[i].src], !rows[i].acc)
      if (rows[i].acc) begin
        `CHK(vector_addr_o, ivaa_pkg::VEC_BASE_ADDR + 20'(2 * rows[i].src))
        `CHK(psw_o, (rows[i].program_status_word & 8'h79) | {5'h0, rows[i].lvl, 1'b0})
        `CHK(cyc >= 8 && cyc <= 13, 1'b1)
      end
    end
    setup(8'h06, '1);
    for (int m = 0; m < 4; m++) begin
      sfr(1'b1, ivaa_pkg::RISE_SEL_ADDR, {7'h0, m[1]});
      sfr(1'b1, ivaa_pkg::FALL_SEL_ADDR, {7'h0, m[0]});
      tick(4);
      ecnt = 0;
      ext_irq_pin_i[0] = 1'b1;
      tick(8);
      ext_irq_pin_i[0] = 1'b0;
      tick(8);
      `CHK(ecnt, int'(m[1]) + int'(m[0]))
      `CHK(flags[0], m != 0)
      setup(8'h06, '1);
    end
    for (int a = 0; a < 2; a++) begin
      sfr(1'b1, ivaa_pkg::RISE_SEL_ADDR + 20'(a), 8'hff);
      sfr(1'b0, ivaa_pkg::RISE_SEL_ADDR + 20'(a), 8'h00);
      `CHK(sfr_rdata_o, 8'h3f)
    end
    sfr(1'b0, 20'hfff3a, 8'h00);
    `CHK(sfr_rdata_o, 8'h00)
    lvl0 = 16'hf7ff;
    lvl1 = 16'hf77b;
    setup(8'h86, '0);
    raise(16'h0884);
    `CHK(vector_addr_o, ivaa_pkg::VEC_BASE_ADDR + 20'd22)
    run = 1'b0;
    tick(3);
    instr(4'b1000, 8'h00);
    run = 1'b1;
    raise(16'h0084);
    `CHK(seen, 1'b0)
    run = 1'b0;
    tick(3);
    instr(4'b0010, 8'h86);
    bcnt = 0;
    raise(16'h0084);
    `CHK(vector_addr_o, ivaa_pkg::VEC_BASE_ADDR + 20'd4)
    `CHK(bcnt >= 2, 1'b1)
    `CHK(flags[7], 1'b1)
    setup(8'h06, '1);
    instr(4'b0100, 8'h00);
    `CHK(push_data, 8'h06)
    tick(7);
    `CHK(handler_start_o, 1'b1)
    `CHK(vector_addr_o, ivaa_pkg::TRAP_VEC_ADDR)
    `CHK(psw_o, 8'h06)
    tick(2);
    instr(4'b0001, 8'h82);
    `CHK(psw_o, 8'h82)
    di = 1'b1;
    instr(4'b0000, 8'h00);
    {di, pop} = 2'b01;
    `CHK(psw_o, 8'h02)
    instr(4'b0000, 8'h86);
    pop = 1'b0;
    `CHK(psw_o, 8'h86)
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
    tick();
    `CHK(psw_o, ivaa_pkg::PSW_RESET)
    `CHK(masks, 16'hffff)
    sfr(1'b0, ivaa_pkg::RISE_SEL_ADDR, 8'h00);
    `CHK(sfr_rdata_o, 8'h00)
    sfr(1'b0, ivaa_pkg::FALL_SEL_ADDR, 8'h00);
    `CHK(sfr_rdata_o, 8'h00)
    summarize();
  end
endmodule
